// ===== dv/port_partner.sv
// Purpose: Module-side model, drives monitored inputs, resolves interrupt
// Assumes: Inputs change just after a rising clock edge
// Notes: Shared interrupt line has a pull-up, so released reads high
`default_nettype none
module port_partner
  import sideband_pkg::*;
(
  // Clock
  input wire logic clk,
  // Interrupt drive from the device
  input wire logic host_int_n_o,
  input wire logic host_int_n_oe,
  // Module outputs and resolved line
  output logic [NUM_IN*NUM_PORTS-1:0] mon_in,
  output logic host_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Open drain: a released line floats up through the pull-up
  assign host_line_n = host_int_n_oe ? host_int_n_o : 1'b1;
  initial mon_in = '0;
  // One module output changes just after an edge
  task automatic set_in(input int k, input logic v);
    @(posedge clk);
    mon_in[k] <= v;
  endtask : set_in
endmodule : port_partner
`default_nettype wire

// ===== dv/port_sideband_tb.sv
// Purpose: Self-checking bench for the port sideband block
// Assumes: Short blink step so blink periods stay a few dozen cycles
// Notes: Expected values come from bench functions, except the LED 6 check, which compares against the design's LED 4
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  fail_count++; $display("[ERR] %0t mismatch", $time); end end
module port_sideband_tb;
  import sideband_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = NUM_PORTS;
  localparam int NL = P*NUM_LED;
  localparam int NI = NUM_IN*P;
  localparam int STEP = 10;
  logic clk, arst_n, chain_head, sync_i, sync_o, sync_oe, chain_in, chain_out;
  led_mode_t led_mode [NL];
  logic [7:0] led_int [NL], on_st [NL], off_st [NL];
  logic int_wr [NL];
  logic [NL-1:0] led_o, led_oe;
  tb_src_t tb_src;
  logic [P-1:0] port_wr;
  logic dev_wr, sys_wr, clr, int_o, int_oe, line_n, c;
  logic [1:0] val_in, en_in;
  logic [2*P-1:0] gpo_val, gpo_oe, ev, eo;
  logic [NI-1:0] mon_in, mon_level;
  edge_sel_t esel [NI];
  logic [FLAG_PORT_W*P-1:0] flags;
  int fail_count, total_checks, cnt, r;
  port_sideband #(.STEP_CYC(STEP)) port_sideband_inst (.clk(clk),
    .arst_n(arst_n), .led_mode(led_mode), .led_intensity(led_int),
    .led_on_steps(on_st), .led_off_steps(off_st), .intensity_wr(int_wr),
    .led_pin_o(led_o), .led_pin_oe(led_oe), .tb_src(tb_src),
    .chain_head(chain_head), .led_clock_sync_pin_i(sync_i),
    .led_clock_sync_pin_o(sync_o), .led_clock_sync_pin_oe(sync_oe),
    .led_chain_in(chain_in), .led_chain_out(chain_out),
    .gpo_port_wr(port_wr), .gpo_dev_wr(dev_wr), .gpo_sys_wr(sys_wr),
    .gpo_val_in(val_in), .gpo_en_in(en_in), .gpo_val(gpo_val),
    .gpo_oe(gpo_oe), .mon_in(mon_in), .edge_sel(esel),
    .flag_clr_rd(clr), .mon_level(mon_level), .irq_flags(flags),
    .host_int_n_o(int_o), .host_int_n_oe(int_oe));
  port_partner port_partner_inst (.clk(clk), .host_int_n_o(int_o),
    .host_int_n_oe(int_oe), .mon_in(mon_in), .host_line_n(line_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Strobes held one cycle, value and enable travel as a pair
  task automatic gpo_wr(input logic [P-1:0] pw, input logic dw,
                        input logic sw, input logic [1:0] v, e);
    @(posedge clk);
    port_wr <= pw;
    dev_wr <= dw;
    sys_wr <= sw;
    val_in <= v;
    en_in <= e;
    @(posedge clk);
    port_wr <= '0;
    dev_wr <= 1'b0;
    sys_wr <= 1'b0;
    #1;
    for (int p = 0; p < P; p++) begin
      if (pw[p] || dw || sw) begin
        ev[2*p +: 2] = v;
        eo[2*p +: 2] = e;
      end
    end
    `CHK(gpo_val, ev)
    `CHK(gpo_oe, eo)
  endtask : gpo_wr
  task automatic set_int(input int i, input logic [7:0] v);
    @(posedge clk);
    led_int[i] <= v;
    int_wr[i] <= 1'b1;
    @(posedge clk);
    int_wr[i] <= 1'b0;
  endtask : set_int
  function automatic logic [FLAG_PORT_W*P-1:0] exp_flag(int k, logic v);
    logic [FLAG_PORT_W*P-1:0] f;
    int b;
    f = '0;
    b = (k / NUM_IN) * FLAG_PORT_W + k % NUM_IN;
    if (v && (esel[k] == EDGE_RISE || esel[k] == EDGE_BOTH))
      f[b + FLAG_RISE_POS] = 1'b1;
    if (!v && (esel[k] == EDGE_FALL || esel[k] == EDGE_BOTH))
      f[b + FLAG_FALL_POS] = 1'b1;
    return f;
  endfunction : exp_flag
  // One input edge, bounded wait for the interrupt, then read-clear
  task automatic edge_try(input int k, input logic v);
    logic [FLAG_PORT_W*P-1:0] e;
    int n;
    e = exp_flag(k, v);
    port_partner_inst.set_in(k, v);
    n = 0;
    while (int_oe !== 1'b1 && n < ((e != 0) ? IRQ_MAX_CYC : 20)) begin
      tick(1);
      n++;
    end
    tick(1);
    `CHK(flags, e)
    `CHK(int_oe, e != 0)
    `CHK(line_n, e == 0)
    `CHK(n < IRQ_MAX_CYC, 1'b1)
    `CHK(mon_level[k], v)
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(3);
    `CHK(flags, '0)
    `CHK(int_oe, 1'b0)
  endtask : edge_try
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // Watchdog: a clean run takes a few thousand cycles
  initial begin
    #200_000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    arst_n = 1'b0;
    {chain_head, chain_in, sync_i, dev_wr, sys_wr, clr} = '0;
    {port_wr, val_in, en_in} = '0;
    tb_src = TB_INTERNAL;
    for (int i = 0; i < NL; i++) begin
      led_mode[i] = LED_OFF;
      {led_int[i], int_wr[i]} = '0;
      on_st[i] = 8'h02;
      off_st[i] = 8'h03;
    end
    for (int k = 0; k < NI; k++) esel[k] = EDGE_NONE;
    void'($urandom(87174));
    tick(3);
    `CHK(led_oe, '0)
    `CHK(gpo_oe, '0)
    `CHK(gpo_val, {P{GPO_B_RST, GPO_A_RST}})
    `CHK(int_oe, 1'b0)
    @(posedge clk);
    arst_n <= 1'b1;
    tick(2);
    `CHK(led_oe, '1)
    `CHK(led_o, '1)
    ev = {P{GPO_B_RST, GPO_A_RST}};
    eo = '0;
    // Values go out before enables, then random updates at each scope
    gpo_wr(4'h4, 1'b0, 1'b0, 2'b10, 2'b00);
    gpo_wr(4'h4, 1'b0, 1'b0, 2'b10, 2'b11);
    for (int t = 0; t < 8; t++) begin
      r = $urandom;
      gpo_wr(r[3:0], r[4], r[5] & ~r[4], r[7:6], r[9:8]);
    end
    $display("done outputs");
    // One edge code per input, cycling through all four codes, both directions
    // Input 0 gets a rising code so its design checks are exercised
    for (int k = 0; k < NI; k++) begin
      @(posedge clk);
      esel[k] <= edge_sel_t'((k + 1) % 4);
      tick(1);
      edge_try(k, 1'b1);
      edge_try(k, 1'b0);
      @(posedge clk);
      esel[k] <= EDGE_NONE;
    end
    $display("done inputs");
    @(posedge clk);
    led_mode[0] <= LED_ON;
    led_mode[1] <= LED_DIM;
    tick(4);
    `CHK(led_o[0], 1'b0)
    cnt = 0;
    repeat (512) begin
      tick(1);
      cnt += !led_o[1];
    end
    `CHK(cnt, 0)
    r = 1 + $urandom % 254;
    set_int(1, r[7:0]);
    tick(300);
    cnt = 0;
    repeat (256) begin
      tick(1);
      cnt += !led_o[1];
    end
    `CHK(cnt >= r - 1 && cnt <= r + 1, 1'b1)
    set_int(4, 8'hff);
    set_int(6, 8'hff);
    @(posedge clk);
    led_mode[4] <= LED_BLINK;
    led_mode[6] <= LED_BLINK;
    tick(2);
    cnt = 0;
    repeat (500) begin
      tick(1);
      cnt += !led_o[4];
      `CHK(led_o[6], led_o[4])
    end
    `CHK(cnt >= 160 && cnt <= 220, 1'b1)
    $display("done leds");
    @(posedge clk);
    tb_src <= TB_SPI_MASTER;
    tick(4);
    `CHK(sync_oe, 1'b1)
    // Driven sync pin carries one edge per blink step
    c = sync_o;
    cnt = 0;
    repeat (40) begin
      tick(1);
      cnt += (sync_o != c);
      c = sync_o;
    end
    `CHK(cnt, 40 / STEP)
    @(posedge clk);
    tb_src <= TB_SPI_SLAVE;
    sync_i <= 1'b1;
    tick(4);
    `CHK(sync_oe, 1'b0)
    `CHK(chain_out, 1'b1)
    @(posedge clk);
    tb_src <= TB_CHAIN_SLAVE;
    chain_in <= 1'b1;
    tick(6);
    `CHK(chain_out, 1'b1)
    @(posedge clk);
    chain_in <= 1'b0;
    tick(6);
    `CHK(chain_out, 1'b0)
    // Chain head sources its own clock onto the chain
    @(posedge clk);
    chain_head <= 1'b1;
    tick(2);
    c = chain_out;
    cnt = 0;
    repeat (40) begin
      tick(1);
      cnt += (chain_out != c);
      c = chain_out;
    end
    `CHK(cnt, 40 / STEP)
    $display("done timebase");
    give_verdict();
  end
endmodule : port_sideband_tb
`default_nettype wire

// ===== hdl/led_driver.sv
// Purpose: One LED: on, off, dimmed or blinking, active-low drive
// Assumes: Shared step and PWM phase from the parent
// Notes: Blink phase restarts only on mode entry, so ports put into blink together stay aligned
`default_nettype none
module led_driver
  import sideband_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Settings and output
  led_cfg_if.drv cfg
);
  logic [7:0] cnt_r;
  logic lit_r;
  logic led_low_r;
  logic bright;

  // Blink phase counter in 2.5 ms steps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 8'h00;
      lit_r <= 1'b1;
    end else if (cfg.mode != LED_BLINK) begin
      cnt_r <= 8'h00;
      lit_r <= 1'b1;
    end else if (cfg.step_tick) begin
      if (cnt_r + 8'h01 >= (lit_r ? cfg.on_steps : cfg.off_steps)) begin
        cnt_r <= 8'h00;
        lit_r <= ~lit_r;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // Zero intensity stays dark, 255 is brightest
  assign bright = cfg.pwm_phase < cfg.intensity;

  // Registered lit level; high drives the pin low to light the LED
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      led_low_r <= 1'b0;
    end else begin
      case (cfg.mode)
        LED_ON: led_low_r <= 1'b1;
        LED_OFF: led_low_r <= 1'b0;
        LED_DIM: led_low_r <= bright;
        LED_BLINK: led_low_r <= bright && lit_r;
        default: led_low_r <= 1'b0;
      endcase
    end
  end
  assign cfg.led_low = led_low_r;

  chk_off_dark: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.mode == LED_OFF |=> !led_low_r)
    else $error("led lit while off");
  chk_zero_dim: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.intensity == 8'h00 && cfg.mode == LED_DIM) |=> !led_low_r)
    else $error("led lit at zero intensity");
endmodule : led_driver
`default_nettype wire

// ===== hdl/port_sideband.sv
// Purpose: Four-port LED, general output and input-interrupt sideband logic
// Assumes: Settings arrive as plain ports from the host-interface block
// Notes: Pins with tri-state carry separate value and enable outputs
`default_nettype none
module port_sideband
  import sideband_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int STEP_CYC = BLINK_STEP_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // LED settings, two LEDs per port
  input wire led_mode_t led_mode [PORTS*NUM_LED],
  input wire logic [7:0] led_intensity [PORTS*NUM_LED],
  input wire logic [7:0] led_on_steps [PORTS*NUM_LED],
  input wire logic [7:0] led_off_steps [PORTS*NUM_LED],
  input wire logic intensity_wr [PORTS*NUM_LED],
  // LED pins, low lights the LED
  output logic [PORTS*NUM_LED-1:0] led_pin_o,
  output logic [PORTS*NUM_LED-1:0] led_pin_oe,
  // LED timebase selection and sync pins
  input wire tb_src_t tb_src,
  input wire logic chain_head,
  input wire logic led_clock_sync_pin_i,
  output logic led_clock_sync_pin_o,
  output logic led_clock_sync_pin_oe,
  input wire logic led_chain_in,
  output logic led_chain_out,
  // General output update requests
  input wire logic [PORTS-1:0] gpo_port_wr,
  input wire logic gpo_dev_wr,
  input wire logic gpo_sys_wr,
  input wire logic [1:0] gpo_val_in,
  input wire logic [1:0] gpo_en_in,
  // General output pins: bit 0 is output A, bit 1 output B
  output logic [2*PORTS-1:0] gpo_val,
  output logic [2*PORTS-1:0] gpo_oe,
  // Monitored inputs and interrupt setup
  input wire logic [NUM_IN*PORTS-1:0] mon_in,
  input wire edge_sel_t edge_sel [NUM_IN*PORTS],
  input wire logic flag_clr_rd,
  output logic [NUM_IN*PORTS-1:0] mon_level,
  output logic [FLAG_PORT_W*PORTS-1:0] irq_flags,
  // Host interrupt, open drain: output level always 0
  output logic host_int_n_o,
  output logic host_int_n_oe
);
  localparam int NL = PORTS * NUM_LED;
  localparam int NI = NUM_IN * PORTS;

  // Edge-select decode, used for rise and fall alike
  function automatic logic edge_on(input edge_sel_t s, input logic rise);
    edge_on = (s == EDGE_BOTH) || (rise ? s == EDGE_RISE : s == EDGE_FALL);
  endfunction : edge_on

  // LED timebase
  logic [$clog2(STEP_CYC+1)-1:0] div_r;
  logic int_tick_r;
  logic int_clk_r;
  logic [1:0] sync_ext_r;
  logic ext_prev_r;
  logic ext_tick;
  logic step_tick;
  logic [7:0] pwm_phase_r;
  logic ext_sel;

  // Internal LED clock: square wave, one edge per step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= '0;
      int_tick_r <= 1'b0;
      int_clk_r <= 1'b0;
    end else if (div_r == $bits(div_r)'(STEP_CYC - 1)) begin
      div_r <= '0;
      int_tick_r <= 1'b1;
      int_clk_r <= ~int_clk_r;
    end else begin
      div_r <= div_r + 1'b1;
      int_tick_r <= 1'b0;
    end
  end

  // External LED clock: pin or chain-in, through two flops
  assign ext_sel = (tb_src == TB_SPI_SLAVE) || (tb_src == TB_CHAIN_SLAVE);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_ext_r <= 2'b00;
      ext_prev_r <= 1'b0;
    end else begin
      sync_ext_r <= {sync_ext_r[0], tb_src == TB_SPI_SLAVE ?
                     led_clock_sync_pin_i : led_chain_in};
      ext_prev_r <= sync_ext_r[1];
    end
  end
  assign ext_tick = sync_ext_r[1] != ext_prev_r;
  assign step_tick = ext_sel ? ext_tick : int_tick_r;

  // Sync pin drive and chain repeat
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      led_clock_sync_pin_o <= 1'b0;
      led_clock_sync_pin_oe <= 1'b0;
      led_chain_out <= 1'b0;
    end else begin
      led_clock_sync_pin_o <= int_clk_r;
      led_clock_sync_pin_oe <= tb_src == TB_SPI_MASTER;
      led_chain_out <= chain_head ? int_clk_r : sync_ext_r[1];
    end
  end

  // Shared PWM phase, free running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_phase_r <= 8'h00;
    end else begin
      pwm_phase_r <= pwm_phase_r + 8'h01;
    end
  end

  // LEDs
  logic [7:0] intensity_r [NL];
  generate
    for (genvar i = 0; i < NL; i++) begin : g_led
      led_cfg_if cfg_if ();
      // Intensity held here so its reset is zero
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          intensity_r[i] <= INTENSITY_RST;
        end else if (intensity_wr[i]) begin
          intensity_r[i] <= led_intensity[i];
        end
      end
      assign cfg_if.mode = led_mode[i];
      assign cfg_if.intensity = intensity_r[i];
      assign cfg_if.on_steps = led_on_steps[i] < BLINK_MIN_STEPS ?
                               BLINK_MIN_STEPS : led_on_steps[i];
      assign cfg_if.off_steps = led_off_steps[i] < BLINK_MIN_STEPS ?
                                BLINK_MIN_STEPS : led_off_steps[i];
      assign cfg_if.step_tick = step_tick;
      assign cfg_if.pwm_phase = pwm_phase_r;
      led_driver u_led (
        .clk(clk),
        .arst_n(arst_n),
        .cfg(cfg_if)
      );
      // Pin released in reset, high when dark
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          led_pin_o[i] <= 1'b1;
          led_pin_oe[i] <= 1'b0;
        end else begin
          led_pin_o[i] <= ~cfg_if.led_low;
          led_pin_oe[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // General outputs
  // System broadcast and device write hit every port; the host
  // is trusted to write values before setting enables.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < PORTS; p++) begin
        gpo_val[2*p] <= GPO_A_RST;
        gpo_val[2*p+1] <= GPO_B_RST;
      end
      gpo_oe <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (gpo_port_wr[p] || gpo_dev_wr || gpo_sys_wr) begin
          gpo_val[2*p +: 2] <= gpo_val_in;
          gpo_oe[2*p +: 2] <= gpo_en_in;
        end
      end
    end
  end

  // Inputs and interrupt
  logic [NI-1:0] in_s1_r;
  logic [NI-1:0] in_s2_r;
  logic [NI-1:0] in_prev_r;
  logic [NI-1:0] rise_ev;
  logic [NI-1:0] fall_ev;
  logic prev_valid_r;

  // Two-flop synchroniser, then an edge history flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      in_prev_r <= '0;
      prev_valid_r <= 1'b0;
      mon_level <= '0;
    end else begin
      in_s1_r <= mon_in;
      in_s2_r <= in_s1_r;
      in_prev_r <= in_s2_r;
      prev_valid_r <= 1'b1;
      mon_level <= in_s2_r;
    end
  end

  // Skip the first sample; an input already high out of reset still reads as a rise
  always_comb begin
    for (int k = 0; k < NI; k++) begin
      rise_ev[k] = prev_valid_r && in_s2_r[k] && !in_prev_r[k] &&
                   edge_on(edge_sel[k], 1'b1);
      fall_ev[k] = prev_valid_r && !in_s2_r[k] && in_prev_r[k] &&
                   edge_on(edge_sel[k], 1'b0);
    end
  end

  // Sticky flags; a new event beats the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_flags <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        for (int j = 0; j < NUM_IN; j++) begin
          irq_flags[FLAG_PORT_W*p+FLAG_RISE_POS+j] <=
            rise_ev[NUM_IN*p+j] ||
            (irq_flags[FLAG_PORT_W*p+FLAG_RISE_POS+j] && !flag_clr_rd);
          irq_flags[FLAG_PORT_W*p+FLAG_FALL_POS+j] <=
            fall_ev[NUM_IN*p+j] ||
            (irq_flags[FLAG_PORT_W*p+FLAG_FALL_POS+j] && !flag_clr_rd);
        end
      end
    end
  end

  // Open drain: pull low while any flag stands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_int_n_o <= 1'b0;
      host_int_n_oe <= 1'b0;
    end else begin
      host_int_n_o <= 1'b0;
      host_int_n_oe <= |irq_flags;
    end
  end

  chk_rise_flag: assert property (@(posedge clk) disable iff (!arst_n)
    rise_ev[0] |=> irq_flags[FLAG_RISE_POS] ##1 host_int_n_oe)
    else $error("rise event not flagged");
  chk_irq_latency: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(in_s2_r[0]) && edge_on(edge_sel[0], 1'b1)
    |-> ##[1:5] host_int_n_oe)
    else $error("interrupt late");
  chk_no_edge: assert property (@(posedge clk) disable iff (!arst_n)
    (edge_sel[0] == EDGE_NONE) |-> !rise_ev[0] && !fall_ev[0])
    else $error("masked edge fired");
  chk_irq_drive: assert property (@(posedge clk) disable iff (!arst_n)
    host_int_n_oe |-> !host_int_n_o)
    else $error("interrupt driven high");
  chk_led_drive: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n) |-> ##1 led_pin_oe[0])
    else $error("led pin not driven");
  chk_gpo_write: assert property (@(posedge clk) disable iff (!arst_n)
    gpo_dev_wr |=> gpo_oe[1:0] == $past(gpo_en_in))
    else $error("device write missed");
  chk_level_seen: assert property (@(posedge clk) disable iff (!arst_n)
    mon_level == $past(in_s2_r))
    else $error("level not reported");
  chk_sync_oe: assert property (@(posedge clk) disable iff (!arst_n)
    (tb_src == TB_SPI_SLAVE) |=> !led_clock_sync_pin_oe)
    else $error("slave drives sync pin");
endmodule : port_sideband
`default_nettype wire

// ===== inc/led_cfg_if.sv
// Purpose: Carries one LED's settings and the shared timebase to a driver
// Assumes: Single clock domain
// Notes: Timebase ticks are one-cycle pulses
`default_nettype none
interface led_cfg_if;
  import sideband_pkg::*;
  sideband_pkg::led_mode_t mode;
  logic [7:0] intensity;
  logic [7:0] on_steps;
  logic [7:0] off_steps;
  logic step_tick;
  logic [7:0] pwm_phase;
  logic led_low;
  modport ctrl (output mode, intensity, on_steps, off_steps, step_tick,
                output pwm_phase, input led_low);
  modport drv (input mode, intensity, on_steps, off_steps, step_tick,
               input pwm_phase, output led_low);
endinterface : led_cfg_if
`default_nettype wire

// ===== inc/sideband_pkg.sv
// Purpose: Shared constants and types for the port LED and sideband block
// Assumes: 100 MHz core clock, four ports, two LEDs and three inputs a port
// Notes: Blink times are in 2.5 ms steps, 1..255 steps each
`default_nettype none
package sideband_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NUM_IN = 3;
  localparam int NUM_LED = 2;
  localparam int CLK_HZ = 100_000_000;
  // Blink step time in microseconds and its cycle count
  localparam int BLINK_STEP_US = 2500;
  localparam int BLINK_STEP_CYC = BLINK_STEP_US * (CLK_HZ / 1_000_000);
  // Shortest and longest blink times, in steps (2.5 ms and 637.5 ms)
  localparam logic [7:0] BLINK_MIN_STEPS = 8'h01;
  localparam logic [7:0] BLINK_MAX_STEPS = 8'hff;
  // Interrupt latency limit in microseconds and cycles
  localparam int IRQ_MAX_US = 50;
  localparam int IRQ_MAX_CYC = IRQ_MAX_US * (CLK_HZ / 1_000_000);
  // Reset values
  localparam logic [7:0] INTENSITY_RST = 8'h00;
  localparam logic GPO_A_RST = 1'b1;
  localparam logic GPO_B_RST = 1'b0;
  // Flag layout: per port, rise bits [2:0] then fall bits [5:3]
  localparam int FLAG_RISE_POS = 0;
  localparam int FLAG_FALL_POS = 3;
  localparam int FLAG_PORT_W = 6;

  typedef enum logic [1:0] {
    LED_OFF, LED_ON, LED_DIM, LED_BLINK
  } led_mode_t;

  typedef enum logic [1:0] {
    EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH
  } edge_sel_t;

  // LED timebase source
  typedef enum logic [1:0] {
    TB_INTERNAL, TB_SPI_MASTER, TB_SPI_SLAVE, TB_CHAIN_SLAVE
  } tb_src_t;
endpackage : sideband_pkg
`default_nettype wire
